/* vis_seq_regs.svh */
// constants of the vectored interrupt sequencer: offsets, fields, counts
`ifndef VIS_SEQ_REGS_SVH
`define VIS_SEQ_REGS_SVH

// register file locations
`define VIS_RF_ADDR_W 7
`define VIS_RF_ENABLE 7'h2f
`define VIS_RF_SERIAL_REQ 7'h3d
`define VIS_RF_TIMER_REQ 7'h3e
`define VIS_RF_PIN_REQ 7'h3f

// field positions
`define VIS_EN_PIN_BIT 0
`define VIS_EN_TIMER_BIT 1
`define VIS_EN_SERIAL_BIT 2
`define VIS_REQ_FLAG_BIT 0

// reset values
`define VIS_ENABLE_RESET 3'h0
`define VIS_REQ_RESET 1'h0
`define VIS_INTE_RESET 1'h0
`define VIS_PSW_CLEAR 5'h00

// instruction cycle timing in clocks
`define VIS_CYCLE_CLKS 16
`define VIS_PHASE_CLKS 4
`define VIS_CNT_W 4
`define VIS_SAMPLE_CNT 4'h7
`define VIS_LAST_CNT 4'hf

// vector addresses by source
`define VIS_VEC_PIN 16'h0003
`define VIS_VEC_TIMER 16'h0002
`define VIS_VEC_SERIAL 16'h0001
`define VIS_VEC_NONE 16'h0000

`endif

/* vis_seq_pkg.sv */
// types of the vectored interrupt sequencer
package vis_seq_pkg;

  // sequencing state of the current instruction cycle
  typedef enum logic [3:0] {
    VIS_EXEC = 4'b0001,
    VIS_MOVT2 = 4'b0010,
    VIS_SKIPNOP = 4'b0100,
    VIS_INTCYC = 4'b1000
  } vis_seq_state_t;

  // instruction class reported by the cpu sequencer for this cycle
  typedef struct packed {
    logic table_move_instruction;
    logic enable_irq_instruction;
    logic disable_irq_instruction;
    logic return_from_irq_instruction;
    logic stop_instruction;
    logic skip_met;
  } vis_cpu_ctl_t;

  // one-cycle request events from the peripherals
  typedef struct packed {
    logic serial;
    logic timer;
    logic pin;
  } vis_irq_evt_t;

  // register file access from the cpu
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [3:0] wdata;
  } vis_rf_req_t;

  typedef struct packed {
    logic [3:0] cnt;
  } vis_phase_state_t;

endpackage : vis_seq_pkg

/* vis_phase_counter.sv */
// instruction cycle counter: sixteen clocks in four machine phases
`timescale 1ns/1ns
`include "vis_seq_regs.svh"

module vis_phase_counter
  import vis_seq_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  output logic [1:0] phase,
  output logic [3:0] cnt,
  output logic sample_edge,
  output logic cycle_end
);

  vis_phase_state_t s_ff;
  vis_phase_state_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.cnt = s_ff.cnt + 4'h1;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // phase index is clock count divided by the phase length
  assign phase = s_ff.cnt[3:2];
  assign cnt = s_ff.cnt;
  // clock before the third machine phase begins
  assign sample_edge = (s_ff.cnt == `VIS_SAMPLE_CNT);
  assign cycle_end = (s_ff.cnt == `VIS_LAST_CNT);

endmodule : vis_phase_counter

/* vis_sequencer.sv */
// vectored interrupt sequencer: request flags, enables, acceptance timing
`timescale 1ns/1ns
`include "vis_seq_regs.svh"

module vis_sequencer
  import vis_seq_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire vis_cpu_ctl_t cpu_ctl,
  input wire vis_irq_evt_t irq_evt,
  input wire logic timer_counter_clear,
  input wire logic [4:0] program_status_word,
  input wire vis_rf_req_t rf_req,
  output logic [3:0] rf_rdata,
  output logic [1:0] phase,
  output logic cycle_end,
  output logic int_cycle,
  output logic nop_slot,
  output logic stack_push,
  output logic psw_clear,
  output logic psw_restore,
  output logic [4:0] saved_psw,
  output logic [15:0] vector_addr
);

  typedef struct packed {
    vis_seq_state_t state;
    logic pin_req;
    logic timer_req;
    logic serial_req;
    logic [2:0] enable;
    logic inte;
    logic inte_arm;
    logic hit;
    logic [4:0] irq_stack;
    logic [15:0] vector;
    logic [3:0] rdata;
    logic push;
    logic clr_psw;
    logic restore;
  } vis_seq_reg_t;

  vis_seq_reg_t s_ff;
  vis_seq_reg_t nxt_s;

  logic sample_edge;

  vis_phase_counter u_phase (
    .clock(clock),
    .rstn(rstn),
    .phase(phase),
    .cnt(),
    .sample_edge(sample_edge),
    .cycle_end(cycle_end)
  );

  // one-hot grant, pin first, serial last
  function automatic logic [2:0] prio_pick(input logic [2:0] pend);
    logic [2:0] g;
    g = 3'h0;
    if (pend[`VIS_EN_PIN_BIT]) begin
      g[`VIS_EN_PIN_BIT] = 1'b1;
    end else if (pend[`VIS_EN_TIMER_BIT]) begin
      g[`VIS_EN_TIMER_BIT] = 1'b1;
    end else if (pend[`VIS_EN_SERIAL_BIT]) begin
      g[`VIS_EN_SERIAL_BIT] = 1'b1;
    end
    return g;
  endfunction : prio_pick

  function automatic logic [15:0] vec_of(input logic [2:0] g);
    logic [15:0] v;
    v = `VIS_VEC_NONE;
    case (g)
      3'h1: v = `VIS_VEC_PIN;
      3'h2: v = `VIS_VEC_TIMER;
      3'h4: v = `VIS_VEC_SERIAL;
      default: v = `VIS_VEC_NONE;
    endcase
    return v;
  endfunction : vec_of

  // hardware set dominates every clear so no event is lost
  function automatic logic upd_flag(
    input logic cur,
    input logic hw_set,
    input logic sw_wr,
    input logic sw_val,
    input logic hw_clr
  );
    logic r;
    r = cur;
    if (hw_set) begin
      r = 1'b1;
    end else if (sw_wr) begin
      r = sw_val;
    end else if (hw_clr) begin
      r = 1'b0;
    end
    return r;
  endfunction : upd_flag

  function automatic logic wr_hit(
    input vis_rf_req_t q,
    input logic [6:0] a
  );
    return q.wr && (q.addr == a);
  endfunction : wr_hit

  // an int cycle may only follow a slot that ends a whole instruction
  function automatic logic slot_open(
    input vis_seq_state_t st,
    input vis_cpu_ctl_t c
  );
    logic r;
    r = 1'b0;
    case (st)
      VIS_EXEC: begin
        r = !c.table_move_instruction && !c.enable_irq_instruction &&
            !c.disable_irq_instruction && !c.skip_met;
      end
      VIS_MOVT2: r = 1'b1;
      VIS_SKIPNOP: r = 1'b1;
      VIS_INTCYC: r = 1'b0;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : slot_open

  // register file read decode; unmapped locations read zero
  function automatic logic [3:0] rf_read(
    input logic [6:0] a,
    input vis_seq_reg_t s
  );
    logic [3:0] r;
    r = 4'h0;
    case (a)
      `VIS_RF_ENABLE: r = {1'b0, s.enable};
      `VIS_RF_SERIAL_REQ: r = {3'h0, s.serial_req};
      `VIS_RF_TIMER_REQ: r = {3'h0, s.timer_req};
      `VIS_RF_PIN_REQ: r = {3'h0, s.pin_req};
      default: r = 4'h0;
    endcase
    return r;
  endfunction : rf_read

  // slot that follows a boundary without acceptance
  function automatic vis_seq_state_t next_slot(
    input vis_seq_state_t st,
    input vis_cpu_ctl_t c
  );
    vis_seq_state_t n;
    n = VIS_EXEC;
    case (st)
      VIS_EXEC: begin
        if (c.table_move_instruction) begin
          n = VIS_MOVT2;
        end else if (c.skip_met) begin
          n = VIS_SKIPNOP;
        end else begin
          n = VIS_EXEC;
        end
      end
      VIS_MOVT2: n = VIS_EXEC;
      VIS_SKIPNOP: n = VIS_EXEC;
      VIS_INTCYC: n = VIS_EXEC;
      default: n = VIS_EXEC;
    endcase
    return n;
  endfunction : next_slot

  logic [2:0] req_vec;
  logic [2:0] pending;
  logic [2:0] grant;
  logic exec;
  logic allow;
  logic inte_ok;
  logic accept;
  logic stop_clr;
  logic [3:0] rd_mux;
  // software write strobes per register file location
  logic wr_enable;
  logic wr_pin;
  logic wr_timer;
  logic wr_serial;
  // hardware clears of each request flag
  logic clr_pin;
  logic clr_timer;
  logic clr_serial;
  // instruction classes seen at a plain instruction boundary
  logic ei_end;
  logic di_end;
  logic ret_end;

  always_comb begin
    req_vec = {s_ff.serial_req, s_ff.timer_req, s_ff.pin_req};
    pending = req_vec & s_ff.enable;
    grant = prio_pick(pending);
    exec = (s_ff.state == VIS_EXEC);
    // boundaries where an int cycle may follow
    allow = cycle_end && slot_open(s_ff.state, cpu_ctl);
    // an armed enable takes effect at the end of its follower
    inte_ok = s_ff.inte || s_ff.inte_arm;
    accept = allow && s_ff.hit && inte_ok && (pending != 3'h0);
    stop_clr = cycle_end && exec && cpu_ctl.stop_instruction;
    ei_end = cycle_end && exec && cpu_ctl.enable_irq_instruction;
    di_end = cycle_end && exec && cpu_ctl.disable_irq_instruction;
    ret_end = cycle_end && exec && cpu_ctl.return_from_irq_instruction;
    wr_enable = wr_hit(rf_req, `VIS_RF_ENABLE);
    wr_pin = wr_hit(rf_req, `VIS_RF_PIN_REQ);
    wr_timer = wr_hit(rf_req, `VIS_RF_TIMER_REQ);
    wr_serial = wr_hit(rf_req, `VIS_RF_SERIAL_REQ);
    // int entry clears only the granted source
    clr_pin = accept && grant[`VIS_EN_PIN_BIT];
    clr_timer = (accept && grant[`VIS_EN_TIMER_BIT]) ||
                timer_counter_clear || stop_clr;
    clr_serial = accept && grant[`VIS_EN_SERIAL_BIT];
    rd_mux = rf_read(rf_req.addr, s_ff);
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.push = 1'b0;
    nxt_s.clr_psw = 1'b0;
    nxt_s.restore = 1'b0;

    if (rf_req.rd) begin
      nxt_s.rdata = rd_mux;
    end

    if (wr_enable) begin
      nxt_s.enable = rf_req.wdata[2:0];
    end

    // request flags; int entry clears the granted source
    nxt_s.pin_req = upd_flag(s_ff.pin_req, irq_evt.pin,
      wr_pin,
      rf_req.wdata[`VIS_REQ_FLAG_BIT],
      clr_pin);
    nxt_s.timer_req = upd_flag(s_ff.timer_req, irq_evt.timer,
      wr_timer,
      rf_req.wdata[`VIS_REQ_FLAG_BIT],
      clr_timer);
    nxt_s.serial_req = upd_flag(s_ff.serial_req, irq_evt.serial,
      wr_serial,
      rf_req.wdata[`VIS_REQ_FLAG_BIT],
      clr_serial);

    // recognition point just before the third machine phase
    if (sample_edge && (pending != 3'h0)) begin
      nxt_s.hit = 1'b1;
    end

    if (cycle_end) begin
      // global enable bookkeeping at the instruction boundary
      if (s_ff.inte_arm) begin
        nxt_s.inte = 1'b1;
        nxt_s.inte_arm = 1'b0;
      end
      if (ei_end) begin
        nxt_s.inte_arm = 1'b1;
      end
      if (di_end) begin
        nxt_s.inte = 1'b0;
        nxt_s.inte_arm = 1'b0;
      end
      // return leaves the global enable untouched
      if (ret_end) begin
        nxt_s.restore = 1'b1;
      end
      if (allow) begin
        nxt_s.hit = 1'b0;
      end

      if (accept) begin
        nxt_s.state = VIS_INTCYC;
        nxt_s.vector = vec_of(grant);
        nxt_s.inte = 1'b0;
        nxt_s.inte_arm = 1'b0;
        nxt_s.hit = 1'b0;
        nxt_s.push = 1'b1;
        // single level: a nested entry overwrites the saved word
        nxt_s.irq_stack = program_status_word;
        nxt_s.clr_psw = 1'b1;
        nxt_s.restore = 1'b0;
      end else begin
        nxt_s.state = next_slot(s_ff.state, cpu_ctl);
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_ff.state <= VIS_EXEC;
      s_ff.pin_req <= `VIS_REQ_RESET;
      s_ff.timer_req <= `VIS_REQ_RESET;
      s_ff.serial_req <= `VIS_REQ_RESET;
      s_ff.enable <= `VIS_ENABLE_RESET;
      s_ff.inte <= `VIS_INTE_RESET;
      s_ff.inte_arm <= 1'b0;
      s_ff.hit <= 1'b0;
      s_ff.irq_stack <= `VIS_PSW_CLEAR;
      s_ff.vector <= `VIS_VEC_NONE;
      s_ff.rdata <= 4'h0;
      s_ff.push <= 1'b0;
      s_ff.clr_psw <= 1'b0;
      s_ff.restore <= 1'b0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rf_rdata = s_ff.rdata;
  assign int_cycle = (s_ff.state == VIS_INTCYC);
  assign nop_slot = (s_ff.state == VIS_SKIPNOP);
  assign stack_push = s_ff.push;
  assign psw_clear = s_ff.clr_psw;
  assign psw_restore = s_ff.restore;
  assign saved_psw = s_ff.irq_stack;
  assign vector_addr = s_ff.vector;

endmodule : vis_sequencer

/* vis_seq_assertions.sv */
// port assertions of the vectored interrupt sequencer
`timescale 1ns/1ns
module vis_seq_assertions
  import vis_seq_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire vis_rf_req_t rf_req,
  input wire logic [4:0] program_status_word,
  input wire logic [3:0] rf_rdata,
  input wire logic [1:0] phase,
  input wire logic cycle_end,
  input wire logic int_cycle,
  input wire logic stack_push,
  input wire logic psw_clear,
  input wire logic psw_restore,
  input wire logic [4:0] saved_psw,
  input wire logic [15:0] vector_addr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence s_int_body;
    ##15 (int_cycle && cycle_end) ##1 !int_cycle;
  endsequence
  sequence s_entry;
    stack_push && psw_clear && $past(cycle_end);
  endsequence
  a_int_length: assert property
    ($rose(int_cycle) |-> s_int_body)
    else $error("int cycle not sixteen clocks");
  a_entry_push: assert property
    ($rose(int_cycle) |-> s_entry)
    else $error("int entry without push at boundary");
  a_push_entry: assert property
    (stack_push |-> $rose(int_cycle) ##1 !stack_push)
    else $error("push outside int entry");
  a_psw_saved: assert property
    (stack_push |-> saved_psw == $past(program_status_word))
    else $error("status word not saved");
  a_phase_wrap: assert property
    (cycle_end |-> phase == 2'h3 ##1 phase == 2'h0)
    else $error("phase does not wrap at cycle end");
  a_vector_source: assert property
    (int_cycle |-> vector_addr inside {16'h0001, 16'h0002, 16'h0003})
    else $error("vector not a source vector");
  a_vector_hold: assert property
    (int_cycle && !stack_push |-> $stable(vector_addr))
    else $error("vector moved in int cycle");
  a_enable_upper: assert property
    (rf_req.rd && rf_req.addr == 7'h2f |=> rf_rdata[3] == 1'b0)
    else $error("enable upper bit not zero");
  a_serial_upper: assert property
    (rf_req.rd && rf_req.addr == 7'h3d |=> rf_rdata[3:1] == 3'h0)
    else $error("serial flag upper bits not zero");
  a_restore_pulse: assert property
    (psw_restore |-> ($past(cycle_end) && !int_cycle) ##1 !psw_restore)
    else $error("restore not a one clock boundary pulse");
endmodule : vis_seq_assertions

bind vis_sequencer vis_seq_assertions u_chk (
  .clock, .rstn, .rf_req, .program_status_word, .rf_rdata, .phase,
  .cycle_end, .int_cycle, .stack_push, .psw_clear, .psw_restore,
  .saved_psw, .vector_addr
);

/* vis_cpu_model.sv */
// cpu sequencer model: one instruction class a cycle, keeps the status word
`timescale 1ns/1ns
module vis_cpu_model
  import vis_seq_pkg::*;
(
  input wire logic clock,
  input wire logic cycle_end,
  input wire logic psw_clear,
  input wire vis_cpu_ctl_t next_ctl,
  input wire logic [4:0] next_psw,
  output vis_cpu_ctl_t cpu_ctl,
  output logic [4:0] program_status_word
);
  logic new_cyc_ff = 1'b0;
  initial cpu_ctl = 6'h00;
  initial program_status_word = 5'h00;
  // class is held for the whole cycle, changed only after a boundary
  always @(posedge clock) new_cyc_ff <= cycle_end;
  always @(negedge clock) begin
    if (new_cyc_ff) cpu_ctl <= next_ctl;
    if (psw_clear) program_status_word <= 5'h00;
    else if (new_cyc_ff) program_status_word <= next_psw;
  end
endmodule : vis_cpu_model

/* testbench.sv */
// self-checking bench of the vectored interrupt sequencer
`timescale 1ns/1ns
module testbench;
  import vis_seq_pkg::*;
  localparam vis_cpu_ctl_t k_nop = 6'h00;
  localparam vis_cpu_ctl_t k_tbl = 6'h20;
  localparam vis_cpu_ctl_t k_en = 6'h10;
  localparam vis_cpu_ctl_t k_ret = 6'h04;
  localparam vis_cpu_ctl_t k_di = 6'h08;
  localparam vis_cpu_ctl_t k_stop = 6'h02;
  localparam vis_cpu_ctl_t k_skip = 6'h01;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic timer_counter_clear = 1'b0;
  vis_irq_evt_t irq_evt = 3'h0;
  vis_rf_req_t rf_req = '0;
  vis_cpu_ctl_t cpu_ctl;
  vis_cpu_ctl_t next_ctl = 6'h00;
  logic [4:0] program_status_word;
  logic [3:0] rf_rdata;
  logic [1:0] phase;
  logic cycle_end, int_cycle, nop_slot, psw_clear, slot_int, slot_nop;
  logic psw_restore, slot_rst;
  logic [4:0] saved_psw;
  logic [15:0] vector_addr;
  int n_fail = 0;
  int compares = 0;

  vis_sequencer dut (
    .clock, .rstn, .cpu_ctl, .irq_evt, .timer_counter_clear,
    .program_status_word, .rf_req, .rf_rdata, .phase, .cycle_end,
    .int_cycle, .nop_slot, .stack_push(), .psw_clear, .psw_restore,
    .saved_psw, .vector_addr
  );
  vis_cpu_model cpu (
    .clock, .cycle_end, .psw_clear, .next_ctl, .next_psw(5'h15),
    .cpu_ctl, .program_status_word
  );

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    rf_req <= {1'b0, 1'b1, a, d};
    @(negedge clock);
    rf_req <= '0;
    @(negedge clock);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [3:0] x);
    rf_req <= {1'b1, 1'b0, a, 4'h0};
    @(negedge clock);
    rf_req <= '0;
    chk("rdata", {12'h000, rf_rdata}, {12'h000, x});
    @(negedge clock);
  endtask : rd

  // runs one slot to its end; event e arrives after the sample point
  task automatic instr(input vis_cpu_ctl_t c, input vis_irq_evt_t e);
    next_ctl <= c;
    @(negedge clock);
    next_ctl <= k_nop;
    slot_int = int_cycle;
    slot_nop = nop_slot;
    slot_rst = psw_restore;
    while (phase != 2'h3) @(negedge clock);
    irq_evt <= e;
    @(negedge clock);
    irq_evt <= 3'h0;
    while (!cycle_end) @(negedge clock);
  endtask : instr

  // runs one plain slot with event e arriving before the sample point
  task automatic early_evt(input vis_irq_evt_t e);
    @(negedge clock);
    slot_int = int_cycle;
    irq_evt <= e;
    @(negedge clock);
    irq_evt <= 3'h0;
    while (!cycle_end) @(negedge clock);
  endtask : early_evt

  task automatic is_int(input logic x);
    chk("int", {15'h0000, slot_int}, {15'h0000, x});
  endtask : is_int

  task automatic t_regs;
    rd(7'h2f, 4'h0);
    rd(7'h3d, 4'h0);
    wr(7'h2f, 4'hf);
    rd(7'h2f, 4'h7);
    rd(7'h10, 4'h0);
    wr(7'h3d, 4'hf);
    rd(7'h3d, 4'h1);
    wr(7'h3d, 4'h0);
    rd(7'h3d, 4'h0);
    wr(7'h3e, 4'h1);
    rd(7'h3e, 4'h1);
    wr(7'h3e, 4'h0);
    rd(7'h3e, 4'h0);
  endtask : t_regs

  task automatic t_flags;
    wr(7'h3e, 4'h1);
    timer_counter_clear <= 1'b1;
    @(negedge clock);
    timer_counter_clear <= 1'b0;
    rd(7'h3e, 4'h0);
    rf_req <= {1'b0, 1'b1, 7'h3e, 4'h0};
    irq_evt <= 3'h2;
    @(negedge clock);
    rf_req <= '0;
    irq_evt <= 3'h0;
    @(negedge clock);
    rd(7'h3e, 4'h1);
    instr(k_nop, 3'h4);
    instr(k_stop, 3'h0);
    instr(k_nop, 3'h0);
    rd(7'h3e, 4'h0);
    rd(7'h3d, 4'h1);
  endtask : t_flags

  task automatic t_accept;
    instr(k_nop, 3'h7);
    instr(k_nop, 3'h0);
    is_int(1'b0);
    instr(k_en, 3'h0);
    instr(k_nop, 3'h0);
    is_int(1'b0);
    instr(k_nop, 3'h0);
    is_int(1'b1);
    chk("vec", vector_addr, 16'h0003);
    chk("spsw", {11'h000, saved_psw}, 16'h0015);
    chk("psw", {11'h000, program_status_word}, 16'h0000);
    rd(7'h3f, 4'h0);
    rd(7'h3e, 4'h1);
    instr(k_nop, 3'h0);
    instr(k_ret, 3'h0);
    instr(k_nop, 3'h0);
    is_int(1'b0);
    chk("restore", {15'h0000, slot_rst}, 16'h0001);
    instr(k_en, 3'h0);
    instr(k_ret, 3'h0);
    is_int(1'b0);
    instr(k_nop, 3'h0);
    is_int(1'b1);
    chk("vec", vector_addr, 16'h0002);
    instr(k_en, 3'h0);
    instr(k_nop, 3'h0);
    instr(k_nop, 3'h0);
    chk("vec", vector_addr, 16'h0001);
  endtask : t_accept

  task automatic t_defer;
    wr(7'h2f, 4'h6);
    instr(k_nop, 3'h1);
    instr(k_en, 3'h0);
    instr(k_nop, 3'h0);
    instr(k_nop, 3'h2);
    instr(k_tbl, 3'h0);
    is_int(1'b0);
    instr(k_nop, 3'h0);
    is_int(1'b0);
    instr(k_nop, 3'h0);
    is_int(1'b1);
    chk("vec", vector_addr, 16'h0002);
    rd(7'h3f, 4'h1);
    instr(k_nop, 3'h0);
    instr(k_en, 3'h0);
    instr(k_nop, 3'h4);
    instr(k_skip, 3'h0);
    instr(k_nop, 3'h0);
    chk("nop", {15'h0000, slot_nop}, 16'h0001);
    is_int(1'b0);
    instr(k_nop, 3'h0);
    is_int(1'b1);
    chk("vec", vector_addr, 16'h0001);
  endtask : t_defer

  task automatic t_timing;
    instr(k_en, 3'h0);
    early_evt(3'h2);
    instr(k_nop, 3'h0);
    is_int(1'b1);
    chk("vec", vector_addr, 16'h0002);
    instr(k_en, 3'h0);
    instr(k_nop, 3'h2);
    instr(k_nop, 3'h0);
    is_int(1'b0);
    instr(k_nop, 3'h0);
    is_int(1'b1);
    instr(k_en, 3'h0);
    instr(k_nop, 3'h0);
    instr(k_di, 3'h2);
    instr(k_nop, 3'h0);
    instr(k_nop, 3'h0);
    is_int(1'b0);
    rd(7'h3e, 4'h1);
  endtask : t_timing

  task automatic summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial forever #2 clock = ~clock;

  initial begin
    #20000;
    n_fail++;
    summarize();
  end

  initial begin
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    t_regs();
    t_flags();
    t_accept();
    t_defer();
    t_timing();
    summarize();
  end
endmodule : testbench
